//--- dac_write_pkg.sv
// Shared constants and carrier types for the DAC host write port.
package dac_write_pkg;
	localparam logic [4:0] bus_addr_fixed = 5'h15;
	localparam logic [7:0] burst_pointer = 8'hFF;
	localparam logic [5:0] last_channel = 6'h27;
	localparam logic [5:0] first_channel = 6'h00;
	localparam logic [3:0] bit_count_ack = 4'h8;
	localparam logic [3:0] bit_count_reset = 4'h0;
	localparam logic [1:0] data_byte_reset = 2'h0;
	localparam int channel_count = 40;

	typedef enum logic [2:0] {
		st_idle = 3'b000,
		st_addr = 3'b001,
		st_pointer = 3'b010,
		st_data_hi = 3'b011,
		st_data_lo = 3'b100,
		st_ignore = 3'b101
	} serial_state_t;

	// One register write toward the channel bank.
	typedef struct packed {
		logic [5:0] channel;
		logic register_select_hi;
		logic register_select_lo;
		logic [11:0] data;
	} channel_write_t;
endpackage : dac_write_pkg

//--- dac_host_write_port.sv
// Two-wire serial slave and parallel write port of a 40-channel DAC.
//
// Notes on behaviour
// - Answer address 10101 plus two strap pins.
// - Acknowledge each byte of a matched write frame in ninth clock; other frames get none.
// - Transaction: START, address with write, acknowledge.
// - Pointer byte selects channel, is acknowledged.
// - Address, pointer, two data, STOP updates; the write issues on the second data byte, before STOP.
// - Without STOP, next byte is new pointer.
// - Data bytes carry register select bits.
// - Pointer 0xFF starts burst at channel zero.
// - Burst increments; after channel 39 leaves.
// - No toggle behaviour during burst mode.
// - Select pin low enables parallel only.
// - Parallel strobes need device select low.
// - Write strobe rise latches address, data.
// - Register select pins pick destination.
// - Six-bit address picks each channel.
// - Parallel word is 12-bit straight binary.
`timescale 1ns/1ps
`default_nettype none
module dac_host_write_port
(
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic serial_parallel_select_i,
	input wire logic bus_address_strap_hi_i,
	input wire logic bus_address_strap_lo_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic chip_select_n_i,
	input wire logic write_n_i,
	input wire logic [5:0] channel_address_i,
	input wire logic register_select_hi_i,
	input wire logic register_select_lo_i,
	input wire logic [11:0] parallel_data_word_i,
	output dac_write_pkg::channel_write_t write_o,
	output logic write_valid_o,
	output logic burst_active_o
);
	import dac_write_pkg::*;

	logic [1:0] scl_sync_reg;
	logic [1:0] sda_sync_reg;
	logic [1:0] wr_sync_reg;
	logic scl_last_reg;
	logic sda_last_reg;
	logic wr_last_reg;
	logic [1:0] par_meta_reg;
	logic [1:0] par_sync_reg;
	logic [17:0] par_word_meta_reg;
	logic [17:0] par_word_sync_reg;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic wr_rise;
	serial_state_t state_reg;
	serial_state_t state_next;
	logic [3:0] bit_count_reg;
	logic [7:0] shift_reg;
	logic [7:0] byte_val;
	logic ack_phase_reg;
	logic byte_ok_reg;
	logic [5:0] channel_reg;
	logic burst_reg;
	logic [7:0] data_hi_reg;
	logic addr_match;
	logic serial_on;

	function automatic logic [5:0] next_channel(input logic [5:0] ch);
		next_channel = ch + 6'h01;
	endfunction : next_channel

	// Pin synchronisers; first stage feeds only the second.
	always_ff @(posedge clock_i)
	begin
		scl_sync_reg <= {scl_sync_reg[0], scl_i};
		sda_sync_reg <= {sda_sync_reg[0], sda_i};
		wr_sync_reg <= {wr_sync_reg[0], write_n_i};
		par_meta_reg <= {serial_parallel_select_i, chip_select_n_i};
		par_sync_reg <= par_meta_reg;
		par_word_meta_reg <= {channel_address_i, register_select_hi_i,
			register_select_lo_i, parallel_data_word_i[11:2]};
		par_word_sync_reg <= par_word_meta_reg;
	end

	logic [1:0] par_low_meta_reg;
	logic [1:0] par_low_sync_reg;
	always_ff @(posedge clock_i)
	begin
		par_low_meta_reg <= parallel_data_word_i[1:0];
		par_low_sync_reg <= par_low_meta_reg;
	end

	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			scl_last_reg <= 1'b1;
			sda_last_reg <= 1'b1;
			wr_last_reg <= 1'b1;
		end
		else
		begin
			scl_last_reg <= scl_sync_reg[1];
			sda_last_reg <= sda_sync_reg[1];
			wr_last_reg <= wr_sync_reg[1];
		end
	end

	assign serial_on = par_sync_reg[1];
	assign scl_rise = serial_on && scl_sync_reg[1] && !scl_last_reg;
	assign scl_fall = serial_on && !scl_sync_reg[1] && scl_last_reg;
	assign start_seen = serial_on && scl_sync_reg[1] && scl_last_reg
		&& sda_last_reg && !sda_sync_reg[1];
	assign stop_seen = serial_on && scl_sync_reg[1] && scl_last_reg
		&& !sda_last_reg && sda_sync_reg[1];
	assign wr_rise = wr_sync_reg[1] && !wr_last_reg;
	assign byte_val = shift_reg;
	// Address compare includes the write bit (must be zero).
	assign addr_match = (byte_val[7:3] == bus_addr_fixed)
		&& (byte_val[2] == bus_address_strap_hi_i)
		&& (byte_val[1] == bus_address_strap_lo_i)
		&& !byte_val[0];

	// Bit counter and shift register sample SDA on SCL rise.
	always_ff @(posedge clock_i)
	begin
		if (srst_i || start_seen || stop_seen)
		begin
			bit_count_reg <= bit_count_reset;
			shift_reg <= 8'h00;
		end
		else if (scl_rise && !ack_phase_reg)
		begin
			shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
			bit_count_reg <= bit_count_reg + 4'h1;
		end
		else if (scl_fall && ack_phase_reg)
			bit_count_reg <= bit_count_reset;
	end

	// Byte completes on the falling edge after the eighth bit.
	logic byte_done;
	assign byte_done = scl_fall && !ack_phase_reg
		&& (bit_count_reg == bit_count_ack);

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			st_idle: state_next = st_idle;
			st_addr: if (byte_done)
				state_next = addr_match ? st_pointer : st_ignore;
			st_pointer: if (byte_done)
				state_next = st_data_hi;
			st_data_hi: if (byte_done)
				state_next = st_data_lo;
			st_data_lo: if (byte_done)
				state_next = (burst_reg && channel_reg != last_channel)
					? st_data_hi : st_pointer;
			st_ignore: state_next = st_ignore;
			default: state_next = st_idle;
		endcase
		if (start_seen)
			state_next = st_addr;
		if (stop_seen || !serial_on)
			state_next = st_idle;
	end

	always_ff @(posedge clock_i)
	begin
		if (srst_i)
			state_reg <= st_idle;
		else
			state_reg <= state_next;
	end

	// Acknowledge phase: drive SDA low for the ninth clock.
	always_ff @(posedge clock_i)
	begin
		if (srst_i || start_seen || stop_seen || !serial_on)
		begin
			ack_phase_reg <= 1'b0;
			byte_ok_reg <= 1'b0;
		end
		else if (byte_done)
		begin
			ack_phase_reg <= 1'b1;
			// Idle and ignored frames leave the line to the master.
			byte_ok_reg <= (state_reg == st_addr) ? addr_match
				: (state_reg == st_pointer || state_reg == st_data_hi
				|| state_reg == st_data_lo);
		end
		else if (scl_fall && ack_phase_reg)
		begin
			ack_phase_reg <= 1'b0;
			byte_ok_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			sda_o <= 1'b0;
			sda_oe_o <= 1'b0;
		end
		else
		begin
			sda_o <= 1'b0;
			sda_oe_o <= serial_on && ack_phase_reg && byte_ok_reg
				&& !(scl_fall && ack_phase_reg);
		end
	end

	// Channel pointer and burst mode.
	always_ff @(posedge clock_i)
	begin
		if (srst_i || stop_seen || start_seen || !serial_on)
		begin
			burst_reg <= 1'b0;
			channel_reg <= first_channel;
		end
		else if (byte_done && state_reg == st_pointer)
		begin
			if (byte_val == burst_pointer)
			begin
				burst_reg <= 1'b1;
				channel_reg <= first_channel;
			end
			else
			begin
				burst_reg <= 1'b0;
				channel_reg <= byte_val[5:0];
			end
		end
		else if (byte_done && state_reg == st_data_lo && burst_reg)
		begin
			if (channel_reg == last_channel)
				burst_reg <= 1'b0;
			channel_reg <= next_channel(channel_reg);
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (srst_i)
			data_hi_reg <= 8'h00;
		else if (byte_done && state_reg == st_data_hi)
			data_hi_reg <= byte_val;
	end

	// Output register writes from either port.
	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			write_o <= '0;
			write_valid_o <= 1'b0;
		end
		else if (serial_on && byte_done && state_reg == st_data_lo)
		begin
			write_o.channel <= channel_reg;
			write_o.register_select_hi <= data_hi_reg[7];
			write_o.register_select_lo <= data_hi_reg[6];
			write_o.data <= {data_hi_reg[3:0], byte_val};
			write_valid_o <= 1'b1;
		end
		else if (!serial_on && !par_sync_reg[0] && wr_rise)
		begin
			write_o.channel <= par_word_sync_reg[17:12];
			write_o.register_select_hi <= par_word_sync_reg[11];
			write_o.register_select_lo <= par_word_sync_reg[10];
			write_o.data <= {par_word_sync_reg[9:0],
				par_low_sync_reg};
			write_valid_o <= 1'b1;
		end
		else
			write_valid_o <= 1'b0;
	end

	// Burst mode carries no toggle selection; it is flagged out only.
	assign burst_active_o = burst_reg;

	ack_low_a: assert property (@(posedge clock_i) disable iff (srst_i)
		sda_oe_o |-> !sda_o) else $error("ack not low");
	bad_addr_a: assert property (@(posedge clock_i) disable iff (srst_i)
		byte_done && state_reg == st_addr && !addr_match
		|=> state_reg == st_ignore) else $error("bad address taken");
	ignore_nak_a: assert property (@(posedge clock_i) disable iff (srst_i)
		state_reg == st_ignore |-> !sda_oe_o) else $error("ignored ack");
	burst_start_a: assert property (@(posedge clock_i) disable iff (srst_i)
		byte_done && state_reg == st_pointer && byte_val == burst_pointer
		&& !stop_seen && !start_seen && serial_on
		|=> burst_reg && channel_reg == first_channel)
		else $error("burst not started");
	burst_end_a: assert property (@(posedge clock_i) disable iff (srst_i)
		stop_seen |=> !burst_reg) else $error("burst past stop");
	par_off_a: assert property (@(posedge clock_i) disable iff (srst_i)
		!serial_on |=> !sda_oe_o) else $error("serial active");
	cs_gate_a: assert property (@(posedge clock_i) disable iff (srst_i)
		write_valid_o && !$past(serial_on) |-> !$past(par_sync_reg[0]))
		else $error("write without select");
	chan_range_a: assert property (@(posedge clock_i) disable iff (srst_i)
		burst_reg |-> channel_reg <= last_channel)
		else $error("burst channel out of range");
	serial_wr_a: assert property (@(posedge clock_i) disable iff (srst_i)
		byte_done && state_reg == st_data_lo && serial_on
		|=> write_valid_o && write_o.data[7:0] == $past(byte_val))
		else $error("serial write missing");
	cv_burst: cover property (@(posedge clock_i) burst_reg && channel_reg
		== last_channel && write_valid_o);
	cv_single: cover property (@(posedge clock_i) write_valid_o
		&& serial_on && !burst_reg);
	cv_par: cover property (@(posedge clock_i) write_valid_o && !serial_on);
endmodule : dac_host_write_port
`default_nettype wire

//--- i2c_host_model.sv
// Behavioural two-wire bus master that writes bytes to the port.
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model
(
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	// Both lines start driven high, so they rest high between frames.
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	// A falling data line with the clock high opens every frame.
	task automatic start_frame();
		sda_o = 1'b0;
		#60 scl_o = 1'b0;
	endtask : start_frame

	task automatic stop_frame();
		#40 sda_o = 1'b0;
		#60 scl_o = 1'b1;
		#60 sda_o = 1'b1;
		#100;
	endtask : stop_frame

	// Data moves only while the clock is low; the ninth clock is left free.
	task automatic send_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			#40 sda_o = b[i];
			#60 scl_o = 1'b1;
			#60 scl_o = 1'b0;
		end
		#40 sda_o = 1'b1;
		#60 scl_o = 1'b1;
		#40 ack = ~sda_i;
		#20 scl_o = 1'b0;
	endtask : send_byte
endmodule : i2c_host_model
`default_nettype wire

//--- tb_dac_host_write_port.sv
// Self-checking testbench for the DAC host write port.
`timescale 1ns/1ps
`default_nettype none
module tb_dac_host_write_port;
	import dac_write_pkg::*;
	localparam logic [7:0] dev_w = {bus_addr_fixed, 2'b10, 1'b0};
	logic clock_i, srst_i, sel, m_scl, m_sda, sda_w, sda_o, sda_oe_o;
	logic cs_n, wr_n, rsh, rsl, write_valid_o, burst_active_o;
	logic strap_hi, strap_lo;
	logic [5:0] addr;
	logic [11:0] pdata;
	channel_write_t write_o;
	channel_write_t wq[$];
	int n_errors = 0;
	int num_checks = 0;

	assign sda_w = sda_oe_o ? sda_o : m_sda;

	dac_host_write_port dac_host_write_port_i (.clock_i(clock_i),
		.srst_i(srst_i), .serial_parallel_select_i(sel),
		.bus_address_strap_hi_i(strap_hi), .bus_address_strap_lo_i(strap_lo),
		.scl_i(m_scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
		.chip_select_n_i(cs_n), .write_n_i(wr_n), .channel_address_i(addr),
		.register_select_hi_i(rsh), .register_select_lo_i(rsl),
		.parallel_data_word_i(pdata), .write_o(write_o),
		.write_valid_o(write_valid_o), .burst_active_o(burst_active_o));

	i2c_host_model i2c_host_model_i (.sda_i(sda_w), .scl_o(m_scl),
		.sda_o(m_sda));

	initial
	begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end

	always @(negedge clock_i)
		if (write_valid_o === 1'b1)
			wq.push_back(write_o);

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic end_sim();
		if (n_errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim

	task automatic tx(input logic [7:0] b, input logic exp_ack);
		logic a;
		i2c_host_model_i.send_byte(b, a);
		chk("ack", 32'(a), 32'(exp_ack));
	endtask : tx

	task automatic pair(input logic [1:0] rs, input logic [11:0] d);
		tx({rs, 2'b00, d[11:8]}, 1'b1);
		tx(d[7:0], 1'b1);
	endtask : pair

	task automatic exp_write(input logic [5:0] ch, input logic [1:0] rs,
		input logic [11:0] d);
		channel_write_t w;
		w = 'x;
		for (int n = 0; n < 20 && wq.size() == 0; n++)
			@(negedge clock_i);
		if (wq.size() != 0)
			w = wq.pop_front();
		chk("write", 32'(w), 32'({ch, rs, d}));
		chk("extra", 32'(wq.size()), 32'h0);
	endtask : exp_write

	task automatic par_write(input logic [5:0] a, input logic [1:0] rs,
		input logic [11:0] d, input logic csn);
		@(negedge clock_i);
		{addr, rsh, rsl, pdata, cs_n} = {a, rs, d, csn};
		wr_n = 1'b0;
		repeat (4) @(negedge clock_i);
		wr_n = 1'b1;
		repeat (8) @(negedge clock_i);
		cs_n = 1'b1;
	endtask : par_write

	initial
	begin
		{srst_i, sel, cs_n, wr_n} = 4'hF;
		{addr, rsh, rsl, pdata} = '0;
		{strap_hi, strap_lo} = 2'b10;
		repeat (6) @(negedge clock_i);
		srst_i = 1'b0;
		repeat (4) @(negedge clock_i);
		chk("burst idle", 32'(burst_active_o), 32'h0);
		i2c_host_model_i.start_frame();
		tx(dev_w, 1'b1);
		tx(8'h07, 1'b1);
		pair(2'b11, 12'hA5C);
		i2c_host_model_i.stop_frame();
		exp_write(6'h07, 2'b11, 12'hA5C);
		i2c_host_model_i.start_frame();
		tx(dev_w, 1'b1);
		for (int k = 0; k < 4; k++)
		begin
			tx(8'(32 + k), 1'b1);
			pair(k[1:0], 12'(k * 291 + 7));
			exp_write(6'(32 + k), k[1:0], 12'(k * 291 + 7));
		end
		i2c_host_model_i.stop_frame();
		i2c_host_model_i.start_frame();
		tx(dev_w, 1'b1);
		tx(burst_pointer, 1'b1);
		for (int k = 0; k < channel_count; k++)
		begin
			pair(2'b10, 12'(k * 37));
			exp_write(6'(k), 2'b10, 12'(k * 37));
			chk("burst", 32'(burst_active_o), 32'(k < 39));
		end
		tx(8'h05, 1'b1);
		pair(2'b01, 12'hFFF);
		exp_write(6'h05, 2'b01, 12'hFFF);
		i2c_host_model_i.stop_frame();
		i2c_host_model_i.start_frame();
		tx({bus_addr_fixed, 2'b01, 1'b0}, 1'b0);
		tx(8'h03, 1'b0);
		i2c_host_model_i.stop_frame();
		i2c_host_model_i.start_frame();
		tx({bus_addr_fixed, 2'b10, 1'b1}, 1'b0);
		i2c_host_model_i.stop_frame();
		{strap_hi, strap_lo} = 2'b01;
		i2c_host_model_i.start_frame();
		tx({bus_addr_fixed, 2'b01, 1'b0}, 1'b1);
		tx(8'h02, 1'b1);
		pair(2'b00, 12'h123);
		i2c_host_model_i.stop_frame();
		exp_write(6'h02, 2'b00, 12'h123);
		{strap_hi, strap_lo} = 2'b10;
		par_write(6'h01, 2'b00, 12'h111, 1'b0);
		chk("serial refusals", 32'(wq.size()), 32'h0);
		sel = 1'b0;
		repeat (4) @(negedge clock_i);
		i2c_host_model_i.start_frame();
		tx(dev_w, 1'b0);
		i2c_host_model_i.stop_frame();
		par_write(last_channel, 2'b11, 12'h800, 1'b0);
		exp_write(last_channel, 2'b11, 12'h800);
		par_write(first_channel, 2'b01, 12'h001, 1'b0);
		exp_write(first_channel, 2'b01, 12'h001);
		par_write(6'h12, 2'b10, 12'h5A5, 1'b1);
		chk("deselected", 32'(wq.size()), 32'h0);
		end_sim();
	end

	initial
	begin
		#1000000;
		n_errors++;
		end_sim();
	end
endmodule : tb_dac_host_write_port
`default_nettype wire
